// [logic/fapc_ctrl.sv]
// Flash command controller with lock regions, security and wipe pin
module fapc_ctrl #(
   parameter int unsigned   WIPE_TICKS = fapc_pkg::WIPE_TICKS,
   // Arbitrary identifier value
   parameter logic [127:0]  UNIQUE_ID  = 128'h5A5A_0001_0203_0405_0607_0809_0A0B_0C0D
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        wipe_pin_i,
   input  wire logic        slow_tick_i,
   input  wire logic        factory_test_pin_i,
   input  wire logic        prog_entry_line_0_i,
   input  wire logic        prog_entry_line_1_i,
   output logic             fast_prog_mode_o,
   input  wire logic        fast_prog_interface_valid_i,
   input  wire logic [7:0]  fast_prog_interface_cmd_i,
   input  wire logic [15:0] fast_prog_interface_arg_i,
   output logic             fast_prog_interface_ready_o,
   output logic             fast_prog_interface_done_o,
   output logic             fast_prog_interface_fail_o,
   input  wire logic        dbg_req_i,
   output logic             dbg_grant_o,
   input  wire logic [31:0] calib_bits_i,
   output logic             arr_start_o,
   output logic      [2:0]  arr_op_o,
   output logic      [11:0] arr_page_o,
   output logic      [12:0] arr_count_o,
   output logic      [31:0] arr_fill_o,
   input  wire logic        arr_done_i,
   output logic      [3:0]  wait_states_o,
   output logic             secured_o,
   output logic             boot_flash_o,
   output logic             bank_swap_o,
   output logic             lock_abort_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   // True if any lock bit in lo..hi is set
   function automatic logic range_locked(input logic [255:0] lk,
                                         input logic [7:0]   lo,
                                         input logic [7:0]   hi);
      logic r;
      r = 1'b0;
      for (int i = 0; i < fapc_pkg::LOCK_BITS; i++) begin
         if (8'(i) >= lo && 8'(i) <= hi) begin
            r = r | lk[i];
         end
      end
      return r;
   endfunction : range_locked

   // Geometry descriptor word by index
   function automatic logic [31:0] desc_word(input logic [2:0] idx);
      logic [31:0] w;
      case (idx)
         3'h0:    w = 32'h0000_0002;
         3'h1:    w = 32'(fapc_pkg::BANK_KB * 1024);
         3'h2:    w = 32'(fapc_pkg::PAGE_BYTES);
         3'h3:    w = 32'h0000_2000;
         3'h4:    w = 32'h0000_0800;
         3'h5:    w = 32'(fapc_pkg::PAGE_BYTES);
         3'h6:    w = fapc_pkg::BANK1_BASE;
         default: w = 32'h0001_0000;
      endcase
      return w;
   endfunction : desc_word

   ////////////////////////////////////////////////////////////////////////////
   // State
   fapc_pkg::fapc_state_t state_r;
   logic [255:0] lock_r;
   logic [2:0]   general_nv_bit_r;
   logic [31:0]  addr_r;
   logic [3:0]   wait_r;
   logic [31:0]  res_r;
   logic [31:0]  dat_r;
   logic         ack_r;
   logic         cmd_err_r;
   logic         lock_err_r;
   logic         pend_lock_r;
   logic         wipe_pend_r;
   logic         wipe_run_r;
   logic         own_ff_r;
   logic [15:0]  wcnt_r;
   logic         wfired_r;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire        req      = wb_cyc_i & wb_stb_i & ~ack_r;
   wire        wr_stb   = req & wb_we_i;
   wire        rd_stb   = req & ~wb_we_i;
   wire        stat_rd  = rd_stb & (wb_adr_i == fapc_pkg::REG_STATUS);
   wire        wb_cmd   = wr_stb & (wb_adr_i == fapc_pkg::REG_CMD) & wb_sel_i[0];
   wire        idle     = (state_r == fapc_pkg::FAPC_IDLE);

   // Flash byte address to page; both banks sit back to back
   wire        in_b0    = addr_r >= fapc_pkg::BANK0_BASE &&
                          addr_r <  fapc_pkg::BANK1_BASE;
   wire        in_b1    = addr_r >= fapc_pkg::BANK1_BASE &&
                          addr_r <  fapc_pkg::BANK1_BASE + 32'h0010_0000;
   wire        adr_ok   = in_b0 | in_b1;
   wire [11:0] wb_page  = {in_b1, addr_r[19:9]};

   ////////////////////////////////////////////////////////////////////////////
   // Command source: wipe beats bus beats fast programming
   wire fast_prog = ~factory_test_pin_i & ~prog_entry_line_0_i
                    & ~prog_entry_line_1_i;
   assign fast_prog_interface_ready_o = idle & fast_prog & ~general_nv_bit_r[0] & ~wipe_pend_r
                         & ~wb_cmd;
   wire src_wipe = wipe_pend_r;
   wire src_wb   = ~wipe_pend_r & wb_cmd;
   wire src_ff   = fast_prog_interface_valid_i & fast_prog_interface_ready_o;
   wire go       = idle & (src_wipe | src_wb | src_ff);

   wire [7:0]  c_cmd  = src_wipe ? fapc_pkg::CMD_EA :
                        src_wb   ? wb_dat_i[7:0] : fast_prog_interface_cmd_i;
   wire [11:0] c_page = src_wipe ? 12'h000 :
                        src_wb   ? wb_page : fast_prog_interface_arg_i[11:0];
   wire [7:0]  c_idx  = src_wb ? wb_dat_i[15:8] : fast_prog_interface_arg_i[7:0];
   wire [7:0]  c_reg  = c_page[11:4];

   // Sector of the page: two 8K, one 48K, then 64K sectors
   wire        c_small = (c_page[10:5] == 6'h00);
   wire        c_mid   = ~c_small & (c_page[10:7] == 4'h0);
   wire [11:0] s_first = c_small ? {c_page[11:4], 4'h0} :
                         c_mid   ? {c_page[11], 11'h020} :
                                   {c_page[11:7], 7'h00};
   wire [12:0] s_cnt   = c_small ? fapc_pkg::SMALL_PAGES :
                         c_mid   ? fapc_pkg::MID_PAGES :
                                   fapc_pkg::SECT_PAGES;
   wire [7:0]  s_lo    = c_small ? c_reg : c_mid ? {c_page[11], 7'h02} :
                                   {c_page[11:7], 3'h0};
   wire [7:0]  s_hi    = c_small ? c_reg : c_mid ? {c_page[11], 7'h07} :
                                   {c_page[11:7], 3'h7};

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   logic        d_bad;
   logic        d_arr;
   logic        d_chk;
   logic        d_pg;
   logic        d_lka;
   logic [2:0]  d_op;
   logic [11:0] d_first;
   logic [12:0] d_cnt;
   logic [7:0]  d_lo;
   logic [7:0]  d_hi;
   always_comb begin
      d_bad   = 1'b0;
      d_arr   = 1'b0;
      d_chk   = 1'b0;
      d_pg    = 1'b0;
      d_lka   = 1'b0;
      d_op    = fapc_pkg::AOP_WRITE;
      d_first = c_page;
      d_cnt   = 13'h0001;
      d_lo    = c_reg;
      d_hi    = c_reg;
      case (c_cmd)
         fapc_pkg::CMD_WP, fapc_pkg::CMD_WPL: begin
            d_arr = 1'b1;
            d_chk = 1'b1;
            d_pg  = 1'b1;
            d_lka = (c_cmd == fapc_pkg::CMD_WPL);
         end
         fapc_pkg::CMD_EWP, fapc_pkg::CMD_ERASE_WRITE_PAGE_LOCK_CMD: begin
            d_bad = ~c_small;
            d_arr = 1'b1;
            d_chk = 1'b1;
            d_pg  = 1'b1;
            d_lka = (c_cmd == fapc_pkg::CMD_ERASE_WRITE_PAGE_LOCK_CMD);
            d_op  = fapc_pkg::AOP_EWRITE;
         end
         fapc_pkg::CMD_EPA: begin
            d_bad = ~c_small;
            d_arr = 1'b1;
            d_chk = 1'b1;
            d_pg  = 1'b1;
            d_op  = fapc_pkg::AOP_ERASE;
         end
         fapc_pkg::CMD_EB4: begin
            d_arr   = 1'b1;
            d_chk   = 1'b1;
            d_pg    = 1'b1;
            d_op    = fapc_pkg::AOP_ERASE;
            d_first = {c_page[11:3], 3'h0};
            d_cnt   = fapc_pkg::BLK4K_PAGES;
         end
         fapc_pkg::CMD_ES: begin
            d_arr   = 1'b1;
            d_chk   = 1'b1;
            d_pg    = 1'b1;
            d_op    = fapc_pkg::AOP_ERASE;
            d_first = s_first;
            d_cnt   = s_cnt;
            d_lo    = s_lo;
            d_hi    = s_hi;
         end
         fapc_pkg::CMD_EA: begin
            d_arr   = 1'b1;
            d_chk   = 1'b1;
            d_op    = fapc_pkg::AOP_ERASE;
            d_first = 12'h000;
            d_cnt   = fapc_pkg::ALL_PAGES;
            d_lo    = 8'h00;
            d_hi    = 8'hFF;
         end
         // Signature page has its own ops, never part of full erase
         fapc_pkg::CMD_WUS: begin
            d_arr = 1'b1;
            d_op  = fapc_pkg::AOP_SWRITE;
         end
         fapc_pkg::CMD_EUS: begin
            d_arr = 1'b1;
            d_op  = fapc_pkg::AOP_SERASE;
         end
         fapc_pkg::CMD_RUS: begin
            d_arr = 1'b1;
            d_op  = fapc_pkg::AOP_SREAD;
         end
         fapc_pkg::CMD_SLB, fapc_pkg::CMD_CLB, fapc_pkg::CMD_GLB: begin
            d_pg = 1'b1;
         end
         fapc_pkg::CMD_SGPB: begin
            d_bad = (c_idx >= 8'(fapc_pkg::GENERAL_NV_BIT_N));
         end
         // Security bit cannot be cleared by command
         fapc_pkg::CMD_CGPB: begin
            d_bad = (c_idx >= 8'(fapc_pkg::GENERAL_NV_BIT_N)) | (c_idx == 8'h00);
         end
         fapc_pkg::CMD_GETD, fapc_pkg::CMD_GGPB: begin
            d_pg = 1'b0;
         end
         default: begin
            d_bad = 1'b1;
         end
      endcase
      if (src_wb & d_pg & ~adr_ok) begin
         d_bad = 1'b1;
      end
   end

   wire lock_hit = d_chk & range_locked(lock_r, d_lo, d_hi);

   ////////////////////////////////////////////////////////////////////////////
   // Wipe pin filter on slow ticks; fires once per assertion
   localparam logic [15:0] WIPE_LAST = 16'(WIPE_TICKS - 1);
   wire wipe_trig = wipe_pin_i & slow_tick_i & ~wfired_r
                    & (wcnt_r == WIPE_LAST);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wcnt_r   <= 16'h0000;
         wfired_r <= 1'b0;
      end else if (ce_i) begin
         if (~wipe_pin_i) begin
            wcnt_r   <= 16'h0000;
            wfired_r <= 1'b0;
         end else if (slow_tick_i & ~wfired_r) begin
            wcnt_r   <= wipe_trig ? 16'h0000 : wcnt_r + 16'h0001;
            wfired_r <= wipe_trig;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read mux; unmapped offsets read zero
   wire [31:0] status_w = {24'h000000, wipe_pend_r | wipe_run_r, fast_prog,
                           general_nv_bit_r, cmd_err_r, lock_err_r, idle};
   logic [31:0] rd_data;
   always_comb begin
      case (wb_adr_i)
         fapc_pkg::REG_ADDR:   rd_data = addr_r;
         fapc_pkg::REG_STATUS: rd_data = status_w;
         fapc_pkg::REG_RESULT: rd_data = res_r;
         fapc_pkg::REG_WAIT:   rd_data = {28'h0000000, wait_r};
         fapc_pkg::REG_CALIB:  rd_data = calib_bits_i;
         fapc_pkg::REG_UID0:   rd_data = UNIQUE_ID[31:0];
         fapc_pkg::REG_UID1:   rd_data = UNIQUE_ID[63:32];
         fapc_pkg::REG_UID2:   rd_data = UNIQUE_ID[95:64];
         fapc_pkg::REG_UID3:   rd_data = UNIQUE_ID[127:96];
         default:              rd_data = 32'h00000000;
      endcase
   end

   // Bus slave: ack one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         dat_r  <= 32'h00000000;
         addr_r <= 32'h00000000;
         wait_r <= fapc_pkg::WAIT_RST;
      end else if (ce_i) begin
         ack_r <= req;
         if (rd_stb) begin
            dat_r <= rd_data;
         end
         if (wr_stb & (wb_adr_i == fapc_pkg::REG_ADDR)) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) begin
                  addr_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
               end
            end
         end
         if (wr_stb & (wb_adr_i == fapc_pkg::REG_WAIT) & wb_sel_i[0]) begin
            wait_r <= wb_dat_i[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command engine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r     <= fapc_pkg::FAPC_IDLE;
         lock_r      <= '0;
         general_nv_bit_r     <= 3'h0;
         res_r       <= 32'h00000000;
         cmd_err_r   <= 1'b0;
         lock_err_r  <= 1'b0;
         pend_lock_r <= 1'b0;
         wipe_pend_r <= 1'b0;
         wipe_run_r  <= 1'b0;
         own_ff_r    <= 1'b0;
         arr_start_o <= 1'b0;
         arr_op_o    <= fapc_pkg::AOP_WRITE;
         arr_page_o  <= 12'h000;
         arr_count_o <= 13'h0000;
         lock_abort_o <= 1'b0;
         fast_prog_interface_done_o <= 1'b0;
         fast_prog_interface_fail_o <= 1'b0;
      end else if (ce_i) begin
         arr_start_o  <= 1'b0;
         lock_abort_o <= 1'b0;
         fast_prog_interface_done_o  <= 1'b0;
         fast_prog_interface_fail_o  <= 1'b0;
         // Clear-on-read first so a same-cycle set still lands
         if (stat_rd) begin
            cmd_err_r  <= 1'b0;
            lock_err_r <= 1'b0;
         end
         if (wipe_trig) begin
            wipe_pend_r <= 1'b1;
         end
         if (wb_cmd & ~idle) begin
            cmd_err_r <= 1'b1;
         end
         case (state_r)
            fapc_pkg::FAPC_IDLE: begin
               if (go) begin
                  own_ff_r <= src_ff;
                  if (src_wipe) begin
                     wipe_pend_r <= 1'b0;
                     wipe_run_r  <= 1'b1;
                     lock_r      <= '0;
                     general_nv_bit_r[2:1] <= 2'b00;
                     arr_start_o <= 1'b1;
                     arr_op_o    <= d_op;
                     arr_page_o  <= d_first;
                     arr_count_o <= d_cnt;
                     state_r     <= fapc_pkg::FAPC_ARRAY;
                  end else if (d_bad) begin
                     cmd_err_r   <= 1'b1;
                     fast_prog_interface_fail_o <= src_ff;
                  end else if (lock_hit) begin
                     lock_err_r   <= 1'b1;
                     lock_abort_o <= 1'b1;
                     fast_prog_interface_fail_o  <= src_ff;
                  end else if (d_arr) begin
                     arr_start_o <= 1'b1;
                     arr_op_o    <= d_op;
                     arr_page_o  <= d_first;
                     arr_count_o <= d_cnt;
                     pend_lock_r <= d_lka;
                     state_r     <= fapc_pkg::FAPC_ARRAY;
                  end else begin
                     fast_prog_interface_done_o <= src_ff;
                     case (c_cmd)
                        fapc_pkg::CMD_SLB:  lock_r[c_reg] <= 1'b1;
                        fapc_pkg::CMD_CLB:  lock_r[c_reg] <= 1'b0;
                        fapc_pkg::CMD_GLB:  res_r <= {31'h0, lock_r[c_reg]};
                        fapc_pkg::CMD_SGPB: general_nv_bit_r[c_idx[1:0]] <= 1'b1;
                        fapc_pkg::CMD_CGPB: general_nv_bit_r[c_idx[1:0]] <= 1'b0;
                        fapc_pkg::CMD_GGPB: res_r <= {29'h0, general_nv_bit_r};
                        fapc_pkg::CMD_GETD: res_r <= desc_word(c_idx[2:0]);
                        default:            res_r <= res_r;
                     endcase
                  end
               end
            end
            fapc_pkg::FAPC_ARRAY: begin
               // Completion only when the array reports done
               if (arr_done_i) begin
                  state_r     <= fapc_pkg::FAPC_IDLE;
                  pend_lock_r <= 1'b0;
                  fast_prog_interface_done_o <= own_ff_r;
                  if (pend_lock_r) begin
                     lock_r[arr_page_o[11:4]] <= 1'b1;
                  end
                  if (wipe_run_r) begin
                     wipe_run_r <= 1'b0;
                     general_nv_bit_r[0] <= 1'b0;
                  end
               end
            end
            default: begin
               state_r <= fapc_pkg::FAPC_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign wb_dat_o         = dat_r;
   assign wb_ack_o         = ack_r;
   assign fast_prog_mode_o = fast_prog;
   assign dbg_grant_o      = dbg_req_i & ~general_nv_bit_r[0];
   assign arr_fill_o       = fapc_pkg::ERASED_WORD;
   assign wait_states_o    = wait_r;
   assign secured_o        = general_nv_bit_r[0];
   assign boot_flash_o     = general_nv_bit_r[1];
   assign bank_swap_o      = general_nv_bit_r[2];
endmodule : fapc_ctrl

// [logic/fapc_pkg.sv]
// Constants, command codes and types of the flash array protection controller
package fapc_pkg;
   // Array geometry
   localparam int unsigned  BANK_KB      = 1024;
   localparam logic [31:0]  BANK0_BASE   = 32'h0040_0000;
   localparam logic [31:0]  BANK1_BASE   = 32'h0050_0000;
   localparam int unsigned  PAGE_BYTES   = 512;
   localparam int unsigned  PAGE_W       = 12;
   localparam int unsigned  CNT_W        = 13;
   localparam logic [12:0]  SMALL_PAGES  = 13'h0010;
   localparam logic [12:0]  MID_PAGES    = 13'h0060;
   localparam logic [12:0]  SECT_PAGES   = 13'h0080;
   localparam logic [12:0]  BLK4K_PAGES  = 13'h0008;
   localparam logic [12:0]  ALL_PAGES    = 13'h1000;
   localparam int unsigned  LOCK_BITS    = 256;
   localparam int unsigned  GENERAL_NV_BIT_N      = 3;
   localparam logic [31:0]  ERASED_WORD  = 32'hFFFF_FFFF;
   // Wipe pin filter, slow clock ticks
   localparam int unsigned  SLOW_HZ      = 32768;
   localparam int unsigned  WIPE_MIN_MS  = 200;
   localparam int unsigned  WIPE_IGN_MS  = 100;
   localparam int unsigned  WIPE_TRIG_MS = 220;
   localparam int unsigned  WIPE_TICKS   = (WIPE_TRIG_MS * SLOW_HZ + 999) / 1000;
   // Register byte offsets
   localparam logic [7:0]   REG_CMD      = 8'h00;
   localparam logic [7:0]   REG_ADDR     = 8'h04;
   localparam logic [7:0]   REG_STATUS   = 8'h08;
   localparam logic [7:0]   REG_RESULT   = 8'h0C;
   localparam logic [7:0]   REG_WAIT     = 8'h10;
   localparam logic [7:0]   REG_CALIB    = 8'h14;
   localparam logic [7:0]   REG_UID0     = 8'h18;
   localparam logic [7:0]   REG_UID1     = 8'h1C;
   localparam logic [7:0]   REG_UID2     = 8'h20;
   localparam logic [7:0]   REG_UID3     = 8'h24;
   localparam logic [3:0]   WAIT_RST     = 4'h0;
   // Command codes
   localparam logic [7:0]   CMD_GETD     = 8'h00;
   localparam logic [7:0]   CMD_WP       = 8'h01;
   localparam logic [7:0]   CMD_WPL      = 8'h02;
   localparam logic [7:0]   CMD_EWP      = 8'h03;
   localparam logic [7:0]   CMD_ERASE_WRITE_PAGE_LOCK_CMD     = 8'h04;
   localparam logic [7:0]   CMD_EPA      = 8'h05;
   localparam logic [7:0]   CMD_EB4      = 8'h06;
   localparam logic [7:0]   CMD_ES       = 8'h07;
   localparam logic [7:0]   CMD_EA       = 8'h08;
   localparam logic [7:0]   CMD_SLB      = 8'h09;
   localparam logic [7:0]   CMD_CLB      = 8'h0A;
   localparam logic [7:0]   CMD_GLB      = 8'h0B;
   localparam logic [7:0]   CMD_SGPB     = 8'h0C;
   localparam logic [7:0]   CMD_CGPB     = 8'h0D;
   localparam logic [7:0]   CMD_GGPB     = 8'h0E;
   localparam logic [7:0]   CMD_WUS      = 8'h10;
   localparam logic [7:0]   CMD_EUS      = 8'h11;
   localparam logic [7:0]   CMD_RUS      = 8'h12;
   // Array operation codes
   localparam logic [2:0]   AOP_WRITE    = 3'h0;
   localparam logic [2:0]   AOP_EWRITE   = 3'h1;
   localparam logic [2:0]   AOP_ERASE    = 3'h2;
   localparam logic [2:0]   AOP_SWRITE   = 3'h3;
   localparam logic [2:0]   AOP_SERASE   = 3'h4;
   localparam logic [2:0]   AOP_SREAD    = 3'h5;
   typedef enum logic {FAPC_IDLE, FAPC_ARRAY} fapc_state_t;
endpackage : fapc_pkg

// [bench/fapc_array_model.sv]
// Flash array stand-in: finishes each started operation after a delay taken from lat_i at the start
module fapc_array_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic [3:0] lat_i,
   output logic            done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt_r;
   // Countdown per op; delay varies so both prompt and slow answers occur
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i) cnt_r <= 5'h00;
      else if (start_i) cnt_r <= {1'b0, lat_i} + 5'h01;
      else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
         done_o <= (cnt_r == 5'h01);
      end
   end
endmodule : fapc_array_model

// [bench/fapc_ctrl_assertions.sv]
// Concurrent checks on the flash command controller ports
module fapc_ctrl_assertions (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        factory_test_pin_i,
   input wire logic        prog_entry_line_0_i,
   input wire logic        prog_entry_line_1_i,
   input wire logic        fast_prog_mode_o,
   input wire logic        dbg_req_i,
   input wire logic        dbg_grant_o,
   input wire logic        secured_o,
   input wire logic        arr_start_o,
   input wire logic [31:0] arr_fill_o,
   input wire logic        arr_done_i,
   input wire logic        lock_abort_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic busy_r;
   // Op in flight, from start until the array answers
   always_ff @(posedge clk_i) begin
      if (rst_i) busy_r <= 1'b0;
      else if (arr_start_o) busy_r <= 1'b1;
      else if (arr_done_i) busy_r <= 1'b0;
   end
   AST_ACK_NEXT: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged");
   AST_ACK_PULSE: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ONE_OP: assert property (arr_start_o |-> !busy_r)
      else $error("array op started while busy");
   AST_ABORT: assert property (lock_abort_o |-> !arr_start_o ##1 !arr_start_o)
      else $error("aborted command reached the array");
   AST_DBG: assert property (dbg_grant_o == (dbg_req_i && !secured_o))
      else $error("debug grant wrong for security state");
   AST_FP_ENTRY: assert property (fast_prog_mode_o == !(factory_test_pin_i ||
      prog_entry_line_0_i || prog_entry_line_1_i)) else $error("fast mode entry wrong");
   AST_SEC_CLR: assert property ($fell(secured_o) |-> $past(arr_done_i) ||
      $past(arr_done_i, 2)) else $error("security cleared without erase end");
   AST_FILL: assert property (arr_fill_o == 32'hFFFF_FFFF)
      else $error("erased value not all ones");
endmodule : fapc_ctrl_assertions
bind fapc_ctrl fapc_ctrl_assertions chk (.*);

// [bench/tb_top.sv]
// Self-checking bench for the flash command controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, tick = 1'b0, wipe = 1'b0;
   logic        tst = 1'b1, l0 = 1'b0, l1 = 1'b0, dreq = 1'b0, ack, start, sec, done;
   logic        fv = 1'b0, rdy, fdone;
   logic [2:0]  op;
   logic [3:0]  lat = 4'h0, ws;
   logic [11:0] pg;
   logic [12:0] cnt;
   logic [7:0]  adr = 8'h00, fc = 8'h00;
   logic [15:0] fa = 16'h0000;
   logic [31:0] dat = 32'h0, calib = 32'h0, rdo, q, w;
   logic [63:0] rd_q[$], e;
   logic [27:0] op_q[$];
   int          num_errors = 0, checks = 0, cyc_n = 0;
   localparam logic [31:0] AD[6] = '{32'h0040_0000, 32'h0040_2000, 32'h0040_4000,
                                     32'h0041_0000, 32'h0050_0000, 32'h0042_1000};
   localparam logic [24:0] EX[6] = '{{12'h000, 13'h0010}, {12'h010, 13'h0010},
      {12'h020, 13'h0060}, {12'h080, 13'h0080}, {12'h800, 13'h0010}, {12'h108, 13'h0008}};
   // Arbitrary identifier value
   localparam logic [127:0] UID = 128'h1357_9BDF_2468_ACE0_0F1E_2D3C_4B5A_6978;
   fapc_ctrl #(.WIPE_TICKS(4), .UNIQUE_ID(UID)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
      .wipe_pin_i(wipe), .slow_tick_i(tick), .factory_test_pin_i(tst),
      .prog_entry_line_0_i(l0), .prog_entry_line_1_i(l1), .fast_prog_mode_o(),
      .fast_prog_interface_valid_i(fv), .fast_prog_interface_cmd_i(fc), .fast_prog_interface_arg_i(fa), .fast_prog_interface_ready_o(rdy),
      .fast_prog_interface_done_o(fdone), .fast_prog_interface_fail_o(), .dbg_req_i(dreq), .dbg_grant_o(), .calib_bits_i(calib),
      .arr_start_o(start), .arr_op_o(op), .arr_page_o(pg), .arr_count_o(cnt), .arr_fill_o(),
      .arr_done_i(done), .wait_states_o(ws), .secured_o(sec), .boot_flash_o(),
      .bank_swap_o(), .lock_abort_o());
   fapc_array_model arr (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .lat_i(lat), .done_o(done));
   initial forever #5 clk_i = ~clk_i;
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   task automatic bump(input string nm, input logic [31:0] x, s);
      checks++;
      if (s !== x) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask : bump
   task automatic cmp_rd(input logic [31:0] x, s);
      bump("read data", x, s);
   endtask : cmp_rd
   task automatic cmp_op(input logic [27:0] x, s);
      bump("array op", {4'h0, x}, {4'h0, s});
   endtask : cmp_op
   // Classic single cycle; held until ack, one idle cycle after
   task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= wr;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdo;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
      rd_q.push_back({m, x & m});
      wb(1'b0, a, 32'h0);
   endtask : rd
   // Issue a command; polling reads clear sticky flags, so refusals skip it
   task automatic cmd(input logic [7:0] c, input logic [31:0] a, input logic p);
      wb(1'b1, fapc_pkg::REG_ADDR, a);
      wb(1'b1, fapc_pkg::REG_CMD, {24'h0, c});
      if (p) do rd(fapc_pkg::REG_STATUS, 32'h0, 32'h0); while (q[0] !== 1'b1);
   endtask : cmd
   // Random pins, slow tick, hang guard
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      tick <= (cyc_n[2:0] == 3'h0);
      {tst, l0, l1, dreq} <= 4'($urandom);
      lat <= 4'($urandom);
      if (cyc_n == 20000) begin
         num_errors++;
         end_sim;
      end
   end
   // Oldest note against each read and each array start
   always @(posedge clk_i) begin
      if (ack === 1'b1 && !we && rd_q.size() != 0) begin
         e = rd_q.pop_front();
         if (e[63:32] != 32'h0) cmp_rd(e[31:0], rdo & e[63:32]);
      end
      if (start === 1'b1) cmp_op(op_q.size() != 0 ? op_q.pop_front() : 28'h0, {op, pg, cnt});
   end
   initial begin
      void'($urandom(32'h7462F831));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      calib <= $urandom;
      w = $urandom_range(0, 15);
      @(posedge clk_i);
      wb(1'b1, fapc_pkg::REG_CALIB, 32'hFFFF_FFFF);
      rd(fapc_pkg::REG_CALIB, calib, 32'hFFFF_FFFF);
      rd(8'h3C, 32'h0, 32'hFFFF_FFFF);
      wb(1'b1, fapc_pkg::REG_WAIT, w);
      rd(fapc_pkg::REG_WAIT, w, 32'hF);
      cmp_rd(w, {28'h0, ws});
      for (int i = 0; i < 6; i++) begin
         op_q.push_back({fapc_pkg::AOP_ERASE, EX[i]});
         cmd(i == 5 ? fapc_pkg::CMD_EB4 : fapc_pkg::CMD_ES, AD[i], 1'b1);
      end
      cmd(fapc_pkg::CMD_EPA, 32'h0041_0000, 1'b0);
      rd(fapc_pkg::REG_STATUS, 32'h4, 32'h4);
      cmd(fapc_pkg::CMD_EWP, 32'h0041_0000, 1'b0);
      rd(fapc_pkg::REG_STATUS, 32'h4, 32'h4);
      cmd(fapc_pkg::CMD_SLB, 32'h0040_0000, 1'b1);
      cmd(fapc_pkg::CMD_ES, 32'h0040_0000, 1'b0);
      rd(fapc_pkg::REG_STATUS, 32'h3, 32'h3);
      cmd(fapc_pkg::CMD_CLB, 32'h0040_0000, 1'b1);
      op_q.push_back({fapc_pkg::AOP_ERASE, 12'h000, 13'h0010});
      cmd(fapc_pkg::CMD_ES, 32'h0040_0000, 1'b1);
      cmd(fapc_pkg::CMD_SLB, 32'h0040_0000, 1'b1);
      cmd(fapc_pkg::CMD_SGPB, 32'h0, 1'b1);
      rd(fapc_pkg::REG_STATUS, 32'h8, 32'h8);
      op_q.push_back({fapc_pkg::AOP_ERASE, 12'h000, fapc_pkg::ALL_PAGES});
      wipe <= 1'b1;
      while (sec !== 1'b0) @(posedge clk_i);
      wipe <= 1'b0;
      @(posedge clk_i);
      rd(fapc_pkg::REG_STATUS, 32'h1, 32'h9);
      rd(fapc_pkg::REG_UID3, UID[127:96], 32'hFFFF_FFFF);
      op_q.push_back({fapc_pkg::AOP_ERASE, 12'h000, 13'h0010});
      cmd(fapc_pkg::CMD_ES, 32'h0040_0000, 1'b1);
      cmd(fapc_pkg::CMD_GETD, 32'h0, 1'b1);
      rd(fapc_pkg::REG_RESULT, 32'h2, 32'hFFFF_FFFF);
      // Fast programming page erase; held until the port shows ready
      op_q.push_back({fapc_pkg::AOP_ERASE, 12'h810, 13'h0001});
      fv <= 1'b1;
      fc <= fapc_pkg::CMD_EPA;
      fa <= 16'h0810;
      do @(posedge clk_i); while (rdy !== 1'b1);
      fv <= 1'b0;
      while (fdone !== 1'b1) @(posedge clk_i);
      end_sim;
   end
endmodule : tb_top
